// *** rtl/pmc_top.sv ***
// Power-mode controller: normal, idle, stop and shutdown sequencing.
// Assumes a CPU core that pulses instr_done_i at the end of each instruction.
`timescale 1ns/1ps
module pmc_top #(
  parameter int RST_SEQ_CYCLES = pmc_pkg::PMC_RST_SEQ_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic instr_done_i,
  input wire logic irq_pending_i,
  input wire logic int_rst_i,
  input wire logic pin_rst_i,
  input wire logic por_i,
  output logic [7:0] sfr_rdata_o,
  output pmc_pkg::pmc_ctrl_s ctrl_o,
  output pmc_pkg::pmc_mode_e mode_o,
  output logic [15:0] fetch_addr_o,
  output logic wake_irq_o
);
  import pmc_pkg::*;

  pmc_mode_e mode_r;
  pmc_mode_e mode_nxt;
  logic [7:0] pwr_ctrl_r;
  logic [7:0] pwr_ctrl_nxt;
  logic [7:0] reg_ctrl_r;
  logic [7:0] reg_ctrl_nxt;
  logic pend_idle_r;
  logic pend_idle_nxt;
  logic pend_stop_r;
  logic pend_stop_nxt;
  logic pend_off_r;
  logic pend_off_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  pmc_ctrl_s ctrl_r;
  pmc_ctrl_s ctrl_nxt;
  logic wake_r;
  logic wake_nxt;
  logic [15:0] fetch_r;
  logic [15:0] fetch_nxt;
  logic seq_start;
  logic seq_done;
  logic any_rst;
  logic cold_rst;

  assign any_rst = int_rst_i | pin_rst_i | por_i;
  assign cold_rst = pin_rst_i | por_i;

  pmc_reset_seq #(
    .CYCLES(RST_SEQ_CYCLES)
  ) u_seq (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .start_i(seq_start),
    .done_o(seq_done)
  );

  always_comb begin
    mode_nxt = mode_r;
    pwr_ctrl_nxt = pwr_ctrl_r;
    reg_ctrl_nxt = reg_ctrl_r;
    pend_idle_nxt = pend_idle_r;
    pend_stop_nxt = pend_stop_r;
    pend_off_nxt = pend_off_r;
    wake_nxt = 1'b0;
    fetch_nxt = fetch_r;
    seq_start = 1'b0;
    rdata_nxt = rdata_r;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        PMC_PWR_CTRL_ADDR: rdata_nxt = pwr_ctrl_r;
        PMC_REG_CTRL_ADDR: rdata_nxt = reg_ctrl_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    case (mode_r)
      PMC_NORMAL: begin
        if (any_rst) begin
          mode_nxt = PMC_RESET_SEQ;
          seq_start = 1'b1;
        end else begin
          if (instr_done_i) begin
            pend_idle_nxt = 1'b0;
            pend_stop_nxt = 1'b0;
            if (pend_stop_r) begin
              mode_nxt = pend_off_r ? PMC_SHUTDOWN : PMC_STOP;
            end else if (pend_idle_r) begin
              mode_nxt = PMC_IDLE;
            end
          end
          // A new request written as an older instruction ends must not be lost.
          if (sfr_wr_i && sfr_addr_i == PMC_REG_CTRL_ADDR) begin
            reg_ctrl_nxt = sfr_wdata_i;
          end
          if (sfr_wr_i && sfr_addr_i == PMC_PWR_CTRL_ADDR) begin
            pwr_ctrl_nxt = sfr_wdata_i;
            pend_idle_nxt = sfr_wdata_i[PMC_IDLE_BIT];
            pend_stop_nxt = sfr_wdata_i[PMC_STOP_BIT];
            pend_off_nxt = reg_ctrl_r[PMC_REG_OFF_BIT];
          end
        end
      end
      PMC_IDLE: begin
        if (any_rst) begin
          mode_nxt = PMC_RESET_SEQ;
          seq_start = 1'b1;
        end else if (irq_pending_i) begin
          pwr_ctrl_nxt[PMC_IDLE_BIT] = 1'b0;
          wake_nxt = 1'b1;
          mode_nxt = PMC_NORMAL;
        end
      end
      PMC_STOP: begin
        if (any_rst) begin
          mode_nxt = PMC_RESET_SEQ;
          seq_start = 1'b1;
        end
      end
      PMC_SHUTDOWN: begin
        if (cold_rst) begin
          mode_nxt = PMC_RESET_SEQ;
          seq_start = 1'b1;
        end
      end
      PMC_RESET_SEQ: begin
        pwr_ctrl_nxt = PMC_PWR_CTRL_RST;
        reg_ctrl_nxt = PMC_REG_CTRL_RST;
        pend_idle_nxt = 1'b0;
        pend_stop_nxt = 1'b0;
        pend_off_nxt = 1'b0;
        if (seq_done) begin
          fetch_nxt = PMC_RESET_VECTOR;
          mode_nxt = PMC_NORMAL;
        end
      end
      default: begin
        mode_nxt = PMC_RESET_SEQ;
        seq_start = 1'b1;
      end
    endcase
    ctrl_nxt = PMC_CTRL_RUN;
    case (mode_nxt)
      PMC_IDLE: ctrl_nxt.cpu_halt = 1'b1;
      PMC_STOP: begin
        ctrl_nxt.cpu_halt = 1'b1;
        ctrl_nxt.osc_en = 1'b0;
        ctrl_nxt.dig_clk_en = 1'b0;
      end
      PMC_SHUTDOWN: begin
        ctrl_nxt.cpu_halt = 1'b1;
        ctrl_nxt.osc_en = 1'b0;
        ctrl_nxt.dig_clk_en = 1'b0;
        ctrl_nxt.core_pwr_en = 1'b0;
        ctrl_nxt.regulator_en = (mode_r != PMC_SHUTDOWN) ? 1'b1 : 1'b0;
      end
      PMC_RESET_SEQ: ctrl_nxt.cpu_reset = 1'b1;
      default: ctrl_nxt = PMC_CTRL_RUN;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= PMC_NORMAL;
      pwr_ctrl_r <= PMC_PWR_CTRL_RST;
      reg_ctrl_r <= PMC_REG_CTRL_RST;
      pend_idle_r <= 1'b0;
      pend_stop_r <= 1'b0;
      pend_off_r <= 1'b0;
      rdata_r <= 8'h00;
      ctrl_r <= PMC_CTRL_RUN;
      wake_r <= 1'b0;
      fetch_r <= PMC_RESET_VECTOR;
    end else begin
      mode_r <= mode_nxt;
      pwr_ctrl_r <= pwr_ctrl_nxt;
      reg_ctrl_r <= reg_ctrl_nxt;
      pend_idle_r <= pend_idle_nxt;
      pend_stop_r <= pend_stop_nxt;
      pend_off_r <= pend_off_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      wake_r <= wake_nxt;
      fetch_r <= fetch_nxt;
    end
  end

  assign sfr_rdata_o = rdata_r;
  assign ctrl_o = ctrl_r;
  assign mode_o = mode_r;
  assign fetch_addr_o = fetch_r;
  assign wake_irq_o = wake_r;
endmodule

// *** rtl/pmc_pkg.sv ***
// Constants, types and encodings for the power-mode controller.
// Assumes an 8-bit special-function-register port driven by the CPU core.
package pmc_pkg;
  localparam logic [7:0] PMC_PWR_CTRL_ADDR = 8'h87;
  localparam logic [7:0] PMC_REG_CTRL_ADDR = 8'hc9;
  localparam int PMC_IDLE_BIT = 0;
  localparam int PMC_STOP_BIT = 1;
  localparam int PMC_REG_OFF_BIT = 3;
  localparam logic [7:0] PMC_PWR_CTRL_RST = 8'h00;
  localparam logic [7:0] PMC_REG_CTRL_RST = 8'h00;
  localparam logic [15:0] PMC_RESET_VECTOR = 16'h0000;
  localparam int PMC_RST_SEQ_CYCLES = 4;

  typedef enum logic [2:0] {
    PMC_NORMAL = 3'b000,
    PMC_IDLE = 3'b001,
    PMC_STOP = 3'b010,
    PMC_SHUTDOWN = 3'b011,
    PMC_RESET_SEQ = 3'b100
  } pmc_mode_e;

  typedef struct packed {
    logic cpu_halt;
    logic osc_en;
    logic dig_clk_en;
    logic regulator_en;
    logic core_pwr_en;
    logic cpu_reset;
  } pmc_ctrl_s;

  localparam pmc_ctrl_s PMC_CTRL_RUN = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
endpackage

// *** rtl/pmc_reset_seq.sv ***
// Counter that times the core reset sequence.
// Assumes start_i is a one-cycle pulse; done_o pulses when the count ends.
`timescale 1ns/1ps
module pmc_reset_seq #(
  parameter int CYCLES = 4
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic done_o
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (start_i) begin
      cnt_nxt = 8'(CYCLES);
    end else if (cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
      done_nxt = (cnt_r == 8'h01);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;
endmodule

// *** test/pmc_core_model.sv ***
// Core model: ends each instruction one or three cycles after its write.
// Assumes the write strobe is a one-cycle pulse.
`timescale 1ns/1ps
module pmc_core_model (
  input wire logic clock_i,
  input wire logic sfr_wr_i,
  input wire logic slow_i,
  output logic instr_done_o
);
  logic [2:0] pipe_r = 3'h0;
  always @(posedge clock_i) begin
    pipe_r <= {pipe_r[1:0], sfr_wr_i};
  end
  assign instr_done_o = slow_i ? pipe_r[2] : pipe_r[0];
endmodule

// *** test/pmc_top_sva.sv ***
// Checker of mode changes at the controller ports.
// Assumes binding to pmc_top.
`timescale 1ns/1ps
module pmc_top_sva (
  input logic clock_i,
  input logic rst_n_i,
  input logic instr_done_i,
  input logic irq_pending_i,
  input logic int_rst_i,
  input logic pin_rst_i,
  input logic por_i,
  input pmc_pkg::pmc_ctrl_s ctrl_o,
  input pmc_pkg::pmc_mode_e mode_o,
  input logic [15:0] fetch_addr_o,
  input logic wake_irq_o
);
  import pmc_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire any_rst = int_rst_i | pin_rst_i | por_i;
  idle_entry_a: assert property (
    mode_o == PMC_IDLE && $past(mode_o) == PMC_NORMAL |-> $past(instr_done_i))
    else $error("idle entry");
  idle_run_a: assert property (
    mode_o == PMC_IDLE |-> ctrl_o.cpu_halt && ctrl_o.osc_en && ctrl_o.dig_clk_en)
    else $error("idle outputs");
  idle_wake_a: assert property (
    mode_o == PMC_IDLE && irq_pending_i && !any_rst |=> mode_o == PMC_NORMAL && wake_irq_o)
    else $error("idle wake");
  stop_clk_a: assert property (
    mode_o == PMC_STOP |-> ctrl_o.cpu_halt && !ctrl_o.osc_en && !ctrl_o.dig_clk_en)
    else $error("stop outputs");
  stop_hold_a: assert property (
    mode_o == PMC_STOP && !any_rst |=> mode_o == PMC_STOP)
    else $error("stop left");
  shut_hold_a: assert property (
    mode_o == PMC_SHUTDOWN && !pin_rst_i && !por_i |=> mode_o == PMC_SHUTDOWN)
    else $error("shutdown left");
  shut_power_a: assert property (
    mode_o == PMC_SHUTDOWN && $past(mode_o) == PMC_SHUTDOWN |->
    !ctrl_o.regulator_en && !ctrl_o.core_pwr_en)
    else $error("shutdown power");
  rst_enter_a: assert property (
    mode_o == PMC_IDLE && any_rst |=> mode_o == PMC_RESET_SEQ && ctrl_o.cpu_reset)
    else $error("reset entry");
  rst_exit_a: assert property (
    $past(mode_o) == PMC_RESET_SEQ && mode_o != PMC_RESET_SEQ |->
    mode_o == PMC_NORMAL && fetch_addr_o == PMC_RESET_VECTOR)
    else $error("reset exit");
  cover property (mode_o == PMC_IDLE ##1 wake_irq_o);
  cover property (mode_o == PMC_STOP);
  cover property (mode_o == PMC_SHUTDOWN);
endmodule
bind pmc_top pmc_top_sva i_sva (.clock_i, .rst_n_i, .instr_done_i, .irq_pending_i,
  .int_rst_i, .pin_rst_i, .por_i, .ctrl_o, .mode_o, .fetch_addr_o, .wake_irq_o);

// *** test/tb_power_mode_controller.sv ***
// Bench for the power-mode controller: register access and mode changes.
// Assumes the core model ends every written instruction except the 8'hc9 write made while slow is set, which slow drops before it ends.
`timescale 1ns/1ps
module tb_power_mode_controller;
  import pmc_pkg::*;
  logic clock_i = 0, rst_n_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, irq_pending_i = 0;
  logic int_rst_i = 0, pin_rst_i = 0, por_i = 0, slow = 0, instr_done_i, wake_irq_o;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o;
  logic [15:0] fetch_addr_o;
  pmc_ctrl_s ctrl_o;
  pmc_mode_e mode_o;
  int bad_count = 0, comparisons = 0;
  initial forever #2 clock_i = ~clock_i;
  pmc_top i_dut (.clock_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
    .instr_done_i, .irq_pending_i, .int_rst_i, .pin_rst_i, .por_i, .sfr_rdata_o,
    .ctrl_o, .mode_o, .fetch_addr_o, .wake_irq_o);
  pmc_core_model i_core (.clock_i, .sfr_wr_i, .slow_i(slow), .instr_done_o(instr_done_i));
  task automatic results();
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clock_i) sfr_wr_i = 1'b0;
    @(negedge clock_i);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clock_i) sfr_rd_i = 1'b0;
    chk("read data", {8'h00, e}, {8'h00, sfr_rdata_o});
    @(negedge clock_i);
  endtask
  task automatic wm(pmc_mode_e e);
    for (int i = 0; i < 20 && mode_o !== e; i++) @(negedge clock_i);
    chk("mode", e, mode_o);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clock_i) s = 1'b0;
  endtask
  task automatic hold(pmc_mode_e e);
    irq_pending_i = 1'b1;
    repeat (8) @(negedge clock_i);
    chk("mode", e, mode_o);
    irq_pending_i = 1'b0;
  endtask
  initial begin
    #10000;
    bad_count++;
    results();
  end
  initial begin
    repeat (6) @(negedge clock_i);
    rst_n_i = 1'b1;
    rd(8'h87, PMC_PWR_CTRL_RST);
    rd(8'hc9, PMC_REG_CTRL_RST);
    rd(8'h55, 8'h00);
    wr(8'h87, 8'h01);
    wm(PMC_IDLE);
    chk("halt", 1'b1, ctrl_o.cpu_halt);
    chk("clocks", 2'h3, {ctrl_o.osc_en, ctrl_o.dig_clk_en});
    wr(8'h87, 8'h02);
    irq_pending_i = 1'b1;
    wm(PMC_NORMAL);
    chk("wake", 1'b1, wake_irq_o);
    irq_pending_i = 1'b0;
    rd(8'h87, 8'h00);
    wr(8'h87, 8'h01);
    wm(PMC_IDLE);
    pulse(por_i);
    wm(PMC_RESET_SEQ);
    wm(PMC_NORMAL);
    chk("fetch", PMC_RESET_VECTOR, fetch_addr_o);
    slow = 1'b1;
    wr(8'h87, 8'h02);
    wr(8'hc9, 8'h08);
    slow = 1'b0;
    wm(PMC_STOP);
    hold(PMC_STOP);
    pulse(int_rst_i);
    wm(PMC_RESET_SEQ);
    wm(PMC_NORMAL);
    rd(8'hc9, 8'h00);
    wr(8'hc9, 8'h08);
    rd(8'hc9, 8'h08);
    wr(8'h87, 8'h02);
    wm(PMC_SHUTDOWN);
    chk("core power", 1'b0, ctrl_o.core_pwr_en);
    @(negedge clock_i);
    chk("power", 2'h0, {ctrl_o.regulator_en, ctrl_o.core_pwr_en});
    pulse(int_rst_i);
    hold(PMC_SHUTDOWN);
    pulse(pin_rst_i);
    wm(PMC_NORMAL);
    results();
  end
endmodule
